// >>> system_and_mode_control_regs.sv
// System control and mode status registers with power-state control.
`timescale 1ns/100ps
`include "sysmode_regs.svh"
// What this block does
// - Sleep goes to sleep or software standby
// - Standby select survives wake, software clears it
// - Settling code picks 8192 to 131072 states
// - Halt CPU and modules until settling ends
// - Reset source flag: pin sets, watchdog clears
// - Edge select picks falling or rising NMI
// - Host port enable gates the host interface
// - RAM enable resets to 1, kept in standby
// - Mode register fixed bits read 111001
// - Mode bits mirror pins, latched on read
// - Mode 1: external space, ports carry bus
// - Mode 2: ports 1,2 start as inputs
// - Mode 3: single chip, all ports general
// - Modes 1,2: software chooses on-chip RAM
// - Mode taken from pins leaving reset
// - RAM disabled in expanded mode goes off-chip
module system_and_mode_control_regs #(
   parameter int SETTLE_BASE = `SETTLE_BASE_STATES,
   parameter int SETTLE_WIDTH = 18
) (
   input wire logic clk_i, // System clock, 50 MHz.
   input wire logic rst_i, // External pin reset, synchronous.
   input wire logic wdt_reset_i, // Watchdog overflow reset level.
   input wire logic [3:0] wb_adr_i, // Wishbone byte address.
   input wire logic [31:0] wb_dat_i, // Wishbone write data.
   output logic [31:0] wb_dat_o, // Wishbone read data.
   input wire logic wb_we_i, // Wishbone write enable.
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
   input wire logic wb_stb_i, // Wishbone strobe.
   input wire logic wb_cyc_i, // Wishbone cycle.
   output logic wb_ack_o, // Wishbone acknowledge.
   input wire logic sleep_exec_i, // Sleep instruction executed, pulse.
   input wire logic wake_irq_i, // Any interrupt, wakes sleep.
   input wire logic ext_irq_i, // External interrupt, wakes standby.
   input wire logic mode_pin_hi_i, // Mode pin, high bit.
   input wire logic mode_pin_lo_i, // Mode pin, low bit.
   input wire logic nmi_pin_i, // Non-maskable interrupt pin.
   output logic nmi_req_o, // NMI request, one-cycle pulse.
   output logic sleep_o, // Sleep mode active.
   output logic standby_o, // Software standby active.
   output logic cpu_halt_o, // CPU halted.
   output logic module_halt_o, // Supporting modules halted.
   output logic host_if_enable_o, // Host interface enabled.
   output logic ram_on_o, // On-chip RAM enabled.
   output logic ram_offchip_o, // RAM range goes off-chip.
   output logic expanded_o, // Mode 1 or 2, external bus.
   output logic rom_on_o, // On-chip ROM used.
   output logic addr_ports_o, // Ports 1,2 drive address now.
   output logic ports_gpio_o, // Ports 1,2 start as inputs.
   output logic mode_invalid_o // Pins selected mode 0.
);

   // Both reset sources clear the control state the same way; the reset source flag alone tells them apart.
   logic rst_all;
   assign rst_all = rst_i | wdt_reset_i;

   // Register state.
   logic standby_sel_r;
   logic [2:0] settle_sel_r;
   logic reset_source_flag_r;
   logic nonmaskable_edge_select_r;
   logic host_port_enable_r;
   logic ram_enable_r;
   logic [31:0] dat_r;
   logic ack_r;

   // Pin synchronisers and edge history.
   logic [1:0] mode_meta_r;
   logic [1:0] mode_sync_r;
   logic nmi_meta_r;
   logic nmi_sync_r;
   logic nmi_prev_r;
   logic nmi_req_r;

   // Mode captured at reset release.
   sysmode_pkg::op_mode_type mode_r;
   logic mode_taken_r;

   // Power state.
   sysmode_pkg::power_state_type pwr_r;
   sysmode_pkg::power_state_type pwr_nxt;
   logic settle_start_r;
   logic cpu_halt_r;
   logic module_halt_r;

   // Bus decode.
   logic bus_req;
   logic wr_ctrl;
   logic rd_mode;

   // Registered outputs.
   logic host_if_enable_r;
   logic ram_on_r;
   logic ram_offchip_r;
   logic expanded_r;
   logic rom_on_r;
   logic addr_ports_r;
   logic ports_gpio_r;
   logic mode_invalid_r;

   settle_if settle ();

   settle_timer #(
      .BASE_STATES(SETTLE_BASE),
      .CNT_WIDTH(SETTLE_WIDTH)
   ) u_settle (
      .clk_i(clk_i),
      .rst_i(rst_all),
      .link(settle.tmr)
   );

   // Address match of a word register, used by several decodes.
   function automatic logic hit(input logic [3:0] adr,
                                input logic [3:0] reg_adr);
      hit = (adr[3:2] == reg_adr[3:2]);
   endfunction : hit

   // A request is taken once; ack drops the cycle after it was given.
   assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr_ctrl = bus_req && wb_we_i && wb_sel_i[0] &&
                    hit(wb_adr_i, `ADDR_SYS_CTRL);
   assign rd_mode = bus_req && !wb_we_i && hit(wb_adr_i, `ADDR_MODE_STAT);

   // Two flip-flops on the mode and NMI pins before any logic looks at them.
   always_ff @(posedge clk_i) begin
      mode_meta_r <= {mode_pin_hi_i, mode_pin_lo_i};
      mode_sync_r <= mode_meta_r;
      nmi_meta_r <= nmi_pin_i;
      nmi_sync_r <= nmi_meta_r;
   end

   // Bus handshake: every access, mapped or not, is answered in one cycle.
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req;
      end
   end

   // Read data; unmapped addresses read as zero.
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         dat_r <= '0;
      end else if (bus_req && !wb_we_i) begin
         if (hit(wb_adr_i, `ADDR_SYS_CTRL)) begin
            dat_r <= {24'h0, standby_sel_r, settle_sel_r,
                      reset_source_flag_r, nonmaskable_edge_select_r,
                      host_port_enable_r, ram_enable_r};
         end else if (rd_mode) begin
            // The read returns the pin levels latched by this read.
            dat_r <= {24'h0, `MODE_STAT_FIXED |
                      ({6'h0, mode_sync_r} & `MODE_STAT_LIVE_MASK)};
         end else begin
            dat_r <= '0;
         end
      end else begin
         dat_r <= '0;
      end
   end

   // Software-written control fields; the reset source bit is not among them.
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         settle_sel_r <=
            3'(`SYS_CTRL_RESET >> `BIT_SETTLE_LO);
         nonmaskable_edge_select_r <= 1'(`SYS_CTRL_RESET >> `BIT_NMI_EDGE);
         host_port_enable_r <= 1'(`SYS_CTRL_RESET >> `BIT_HOST_EN);
         ram_enable_r <= 1'(`SYS_CTRL_RESET >> `BIT_RAM_EN);
      end else if (wr_ctrl) begin
         settle_sel_r <= wb_dat_i[`BIT_SETTLE_HI:`BIT_SETTLE_LO];
         nonmaskable_edge_select_r <= wb_dat_i[`BIT_NMI_EDGE];
         host_port_enable_r <= wb_dat_i[`BIT_HOST_EN];
         ram_enable_r <= wb_dat_i[`BIT_RAM_EN];
      end
   end

   // Standby select is untouched by wake-up; only a write or a reset clears it.
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         standby_sel_r <= 1'(`SYS_CTRL_RESET >> `BIT_STANDBY_SEL);
      end else if (wr_ctrl) begin
         standby_sel_r <= wb_dat_i[`BIT_STANDBY_SEL];
      end
   end

   // The pin reset wins when both resets are present at once.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         reset_source_flag_r <= 1'b1;
      end else if (wdt_reset_i) begin
         reset_source_flag_r <= 1'b0;
      end
      // Otherwise held: writes and power states leave it alone.
   end

   // The operating mode is caught on the first clock after reset ends,
   // since the reset itself may only load constants.
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         mode_taken_r <= 1'b0;
         mode_r <= sysmode_pkg::MODE_3;
      end else if (!mode_taken_r) begin
         mode_taken_r <= 1'b1;
         mode_r <= sysmode_pkg::op_mode_type'(mode_sync_r);
      end
   end

   // Power state decisions.
   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         sysmode_pkg::PWR_RUN: begin
            if (sleep_exec_i) begin
               pwr_nxt = standby_sel_r ? sysmode_pkg::PWR_STANDBY
                                       : sysmode_pkg::PWR_SLEEP;
            end
         end
         sysmode_pkg::PWR_SLEEP: begin
            if (wake_irq_i) begin
               pwr_nxt = sysmode_pkg::PWR_RUN;
            end
         end
         sysmode_pkg::PWR_STANDBY: begin
            if (ext_irq_i) begin
               pwr_nxt = sysmode_pkg::PWR_SETTLE;
            end
         end
         sysmode_pkg::PWR_SETTLE: begin
            if (settle.done) begin
               pwr_nxt = sysmode_pkg::PWR_RUN;
            end
         end
         default: begin
            pwr_nxt = sysmode_pkg::PWR_RUN;
         end
      endcase
   end

   // Power state register; halt flags follow the next state to stay in step.
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         pwr_r <= sysmode_pkg::PWR_RUN;
         cpu_halt_r <= 1'b0;
         module_halt_r <= 1'b0;
      end else begin
         pwr_r <= pwr_nxt;
         cpu_halt_r <= !pwr_nxt[0];
         module_halt_r <= pwr_nxt[2] | pwr_nxt[3];
      end
   end

   // Start the timer on the entry into settling.
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         settle_start_r <= 1'b0;
      end else begin
         settle_start_r <= (pwr_r == sysmode_pkg::PWR_STANDBY) && ext_irq_i;
      end
   end

   assign settle.start = settle_start_r;
   assign settle.code = settle_sel_r;

   // NMI edge detect on the synchronised pin, polarity from software.
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         nmi_prev_r <= 1'b1;
         nmi_req_r <= 1'b0;
      end else begin
         nmi_prev_r <= nmi_sync_r;
         nmi_req_r <= nonmaskable_edge_select_r ?
                      (nmi_sync_r && !nmi_prev_r) :
                      (!nmi_sync_r && nmi_prev_r);
      end
   end

   // Mode-dependent outputs. Until the mode is taken, the expanded and
   // address outputs stay low so that no port drives a bus by accident.
   always_ff @(posedge clk_i) begin
      if (rst_all) begin
         host_if_enable_r <= 1'b0;
         ram_on_r <= 1'b0;
         ram_offchip_r <= 1'b0;
         expanded_r <= 1'b0;
         rom_on_r <= 1'b0;
         addr_ports_r <= 1'b0;
         ports_gpio_r <= 1'b0;
         mode_invalid_r <= 1'b0;
      end else begin
         host_if_enable_r <= host_port_enable_r;
         expanded_r <= mode_taken_r &&
                       (mode_r == sysmode_pkg::MODE_1 ||
                        mode_r == sysmode_pkg::MODE_2);
         rom_on_r <= mode_taken_r &&
                     (mode_r == sysmode_pkg::MODE_2 ||
                      mode_r == sysmode_pkg::MODE_3);
         addr_ports_r <= mode_taken_r && (mode_r == sysmode_pkg::MODE_1);
         ports_gpio_r <= mode_taken_r &&
                         (mode_r == sysmode_pkg::MODE_2 ||
                          mode_r == sysmode_pkg::MODE_3);
         mode_invalid_r <= mode_taken_r && (mode_r == sysmode_pkg::MODE_0);
         // Single-chip mode always uses its RAM; expanded modes ask software.
         ram_on_r <= ram_enable_r ||
                     (mode_taken_r && mode_r == sysmode_pkg::MODE_3);
         ram_offchip_r <= !ram_enable_r && mode_taken_r &&
                          (mode_r == sysmode_pkg::MODE_1 ||
                           mode_r == sysmode_pkg::MODE_2);
      end
   end

   // Power-state outputs straight from flip-flops, no gate after them.
   assign sleep_o = pwr_r[1];
   assign standby_o = pwr_r[2];
   assign cpu_halt_o = cpu_halt_r;
   assign module_halt_o = module_halt_r;

   // Bus and remaining outputs.
   assign wb_ack_o = ack_r;
   assign wb_dat_o = dat_r;
   assign nmi_req_o = nmi_req_r;
   assign host_if_enable_o = host_if_enable_r;
   assign ram_on_o = ram_on_r;
   assign ram_offchip_o = ram_offchip_r;
   assign expanded_o = expanded_r;
   assign rom_on_o = rom_on_r;
   assign addr_ports_o = addr_ports_r;
   assign ports_gpio_o = ports_gpio_r;
   assign mode_invalid_o = mode_invalid_r;

endmodule : system_and_mode_control_regs

// >>> sysmode_regs.svh
// Register offsets, field positions, reset values and settling counts.
`ifndef SYSMODE_REGS_SVH
`define SYSMODE_REGS_SVH

// Byte addresses of the two registers on the bus, one word each.
`define ADDR_SYS_CTRL 4'h0
`define ADDR_MODE_STAT 4'h4

// Field positions inside the system control register.
`define BIT_STANDBY_SEL 7
`define BIT_SETTLE_HI 6
`define BIT_SETTLE_LO 4
`define BIT_RESET_SRC 3
`define BIT_NMI_EDGE 2
`define BIT_HOST_EN 1
`define BIT_RAM_EN 0

// Reset values and fixed read bits.
`define SYS_CTRL_RESET 8'h09
`define MODE_STAT_FIXED 8'hE4
`define MODE_STAT_LIVE_MASK 8'h03

// Settling count of code 000 in states; each code step up to 100 doubles it.
`define SETTLE_BASE_STATES 32'd8192
`define SETTLE_CODE_TOP 3'h4

`endif

// >>> sysmode_pkg.sv
// Shared types of the system and mode control block.
package sysmode_pkg;

   // Power state, one-hot.
   typedef enum logic [3:0] {
      PWR_RUN = 4'h1,
      PWR_SLEEP = 4'h2,
      PWR_STANDBY = 4'h4,
      PWR_SETTLE = 4'h8
   } power_state_type;

   // Operating mode as read from the two mode pins (high, low).
   typedef enum logic [1:0] {
      MODE_0 = 2'h0,
      MODE_1 = 2'h1,
      MODE_2 = 2'h2,
      MODE_3 = 2'h3
   } op_mode_type;

endpackage : sysmode_pkg

// >>> settle_if.sv
// Link between the control block and its settling timer.
`timescale 1ns/100ps
interface settle_if;
   logic start;
   logic [2:0] code;
   logic done;

   modport ctrl (output start, output code, input done);
   modport tmr (input start, input code, output done);
endinterface : settle_if

// >>> settle_timer.sv
// Oscillator settling timer used on the way out of software standby.
`timescale 1ns/100ps
`include "sysmode_regs.svh"
module settle_timer #(
   parameter int BASE_STATES = `SETTLE_BASE_STATES,
   parameter int CNT_WIDTH = 18
) (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Synchronous reset, active high.
   settle_if.tmr link // Start, code and done.
);

   // The longest count is sixteen times the base and must fit the counter.
   if (CNT_WIDTH < 2 || BASE_STATES < 1 ||
       (longint'(BASE_STATES) << 4) > (longint'(1) << CNT_WIDTH)) begin : g_chk
      $error("settle_timer: counter too narrow for the settling count");
   end

   logic [CNT_WIDTH-1:0] count_r;
   logic busy_r;
   logic done_r;

   // Codes 10x give the top count; unused codes 11x take it too.
   function automatic logic [CNT_WIDTH-1:0] settle_states(
      input logic [2:0] code);
      logic [2:0] shift;
      shift = (code > `SETTLE_CODE_TOP) ? `SETTLE_CODE_TOP : code;
      if (code[2]) begin
         shift = `SETTLE_CODE_TOP;
      end
      settle_states = CNT_WIDTH'(longint'(BASE_STATES) << shift);
   endfunction : settle_states

   // Count the selected number of states, then report once.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_r <= '0;
         busy_r <= 1'b0;
      end else if (link.start) begin
         count_r <= settle_states(link.code) - CNT_WIDTH'(1);
         busy_r <= 1'b1;
      end else if (busy_r) begin
         if (count_r == '0) begin
            busy_r <= 1'b0;
         end else begin
            count_r <= count_r - CNT_WIDTH'(1);
         end
      end
   end

   // Done is a one-cycle pulse on the last counted state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_r <= 1'b0;
      end else begin
         done_r <= busy_r && !link.start && (count_r == '0);
      end
   end

   assign link.done = done_r;

endmodule : settle_timer

// >>> system_and_mode_control_regs_properties.sv
// Concurrent checks on the ports of the system and mode control block.
`timescale 1ns/100ps
module sysmode_properties #(
   parameter int SETTLE_BASE = 8192
) (
   input wire logic clk_i, // System clock.
   input wire logic rst_i, // Pin reset.
   input wire logic wdt_reset_i, // Watchdog reset.
   input wire logic [3:0] wb_adr_i, // Bus address.
   input wire logic wb_we_i, // Bus direction.
   input wire logic [31:0] wb_dat_o, // Read data.
   input wire logic wb_ack_o, // Acknowledge.
   input wire logic sleep_exec_i, // Sleep instruction.
   input wire logic mode_pin_hi_i, // Mode pin, high.
   input wire logic mode_pin_lo_i, // Mode pin, low.
   input wire logic nmi_pin_i, // NMI pin.
   input wire logic nmi_req_o, // NMI request.
   input wire logic sleep_o, // Sleep state.
   input wire logic standby_o, // Standby state.
   input wire logic cpu_halt_o, // CPU halted.
   input wire logic module_halt_o, // Modules halted.
   input wire logic ram_on_o, // RAM enabled.
   input wire logic ram_offchip_o, // RAM range off-chip.
   input wire logic expanded_o, // Expanded mode.
   input wire logic rom_on_o, // ROM used.
   input wire logic addr_ports_o, // Ports carry address.
   input wire logic ports_gpio_o // Ports start as inputs.
);
   localparam int SETTLE_MAX = SETTLE_BASE * 16 + 4;
   logic [2:0] quiet_r;
   int settle_r;
   wire logic mode_rd = wb_ack_o && !wb_we_i && wb_adr_i == 4'h4;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i || wdt_reset_i);

   // Pins pass two sync flops, so only long-quiet pins must show on a read.
   always_ff @(posedge clk_i) begin
      if (rst_i || !$stable(mode_pin_hi_i) || !$stable(mode_pin_lo_i)) begin
         quiet_r <= 3'h0;
      end else if (quiet_r != 3'h7) begin
         quiet_r <= quiet_r + 3'h1;
      end
   end

   // Length of the running settling phase, in states.
   always_ff @(posedge clk_i) begin
      if (module_halt_o && !standby_o) begin
         settle_r <= settle_r + 1;
      end else begin
         settle_r <= 0;
      end
   end

   a_sleep_picks_state: assert property (
      sleep_exec_i && !cpu_halt_o |=> sleep_o != standby_o)
      else $error("sleep instruction entered no power-down state");
   a_sleep_runs_modules: assert property (
      sleep_o |-> cpu_halt_o && !module_halt_o && !standby_o)
      else $error("sleep state with wrong halt outputs");
   a_standby_halts_all: assert property (
      module_halt_o |-> cpu_halt_o && !sleep_o)
      else $error("modules halted while CPU runs");
   a_settle_bounded: assert property (settle_r <= SETTLE_MAX)
      else $error("settling phase ran too long");
   a_nmi_after_edge: assert property (
      nmi_req_o |-> $past(nmi_pin_i, 2) != $past(nmi_pin_i, 5))
      else $error("NMI request without a pin edge");
   a_mode_fixed_bits: assert property (
      mode_rd |-> wb_dat_o[7:2] == 6'h39)
      else $error("mode register fixed bits wrong");
   a_mode_mirrors_pins: assert property (
      mode_rd && quiet_r > 3'h5 |->
      wb_dat_o[1:0] == {mode_pin_hi_i, mode_pin_lo_i})
      else $error("mode status bits differ from pins");
   a_offchip_expanded: assert property (
      ram_offchip_o |-> expanded_o && !ram_on_o)
      else $error("RAM range off-chip outside expanded mode");
   a_single_chip_ram: assert property (
      rom_on_o && !expanded_o |-> ram_on_o && !addr_ports_o)
      else $error("single-chip mode drives address or drops RAM");
   a_mode_port_use: assert property (
      expanded_o |-> addr_ports_o != rom_on_o && ports_gpio_o == rom_on_o)
      else $error("expanded mode port use wrong");

   c_standby_exit: cover property (standby_o ##1 !standby_o);
   c_sleep_entry: cover property ($rose(sleep_o));
   c_nmi_req: cover property (nmi_req_o);
endmodule : sysmode_properties

bind system_and_mode_control_regs sysmode_properties #(
   .SETTLE_BASE(SETTLE_BASE)
) u_props (
   .clk_i, .rst_i, .wdt_reset_i, .wb_adr_i, .wb_we_i, .wb_dat_o,
   .wb_ack_o, .sleep_exec_i, .mode_pin_hi_i, .mode_pin_lo_i, .nmi_pin_i,
   .nmi_req_o, .sleep_o, .standby_o, .cpu_halt_o, .module_halt_o,
   .ram_on_o, .ram_offchip_o, .expanded_o, .rom_on_o, .addr_ports_o,
   .ports_gpio_o
);

// >>> system_and_mode_control_regs_test.sv
// Self-checking bench for the system and mode control registers.
`timescale 1ns/100ps
`include "sysmode_regs.svh"
module system_and_mode_control_regs_test;
   localparam int BASE = 8; // Short settling unit keeps standby runs brief.
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wdt_reset_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_stb_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_ack_o;
   logic sleep_exec_i = 1'b0;
   logic wake_irq_i = 1'b0;
   logic ext_irq_i = 1'b0;
   logic mode_pin_hi_i = 1'b1;
   logic mode_pin_lo_i = 1'b0;
   logic nmi_pin_i = 1'b1;
   logic nmi_req_o, sleep_o, standby_o, cpu_halt_o, module_halt_o;
   logic host_if_enable_o, ram_on_o, ram_offchip_o, expanded_o, rom_on_o;
   logic addr_ports_o, ports_gpio_o, mode_invalid_o;
   logic [31:0] exp_q[$];
   logic [31:0] exp_v;
   int error_cnt = 0;
   int cmp_count = 0;
   int cyc_cnt = 0;
   int nmi_cnt = 0;

   `define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin \
      error_cnt++; $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end

   system_and_mode_control_regs #(.SETTLE_BASE(BASE)) DUT (
      .clk_i, .rst_i, .wdt_reset_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
      .wb_we_i, .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .sleep_exec_i,
      .wake_irq_i, .ext_irq_i, .mode_pin_hi_i, .mode_pin_lo_i, .nmi_pin_i,
      .nmi_req_o, .sleep_o, .standby_o, .cpu_halt_o, .module_halt_o,
      .host_if_enable_o, .ram_on_o, .ram_offchip_o, .expanded_o, .rom_on_o,
      .addr_ports_o, .ports_gpio_o, .mode_invalid_o
   );

   // Free-running 50 MHz system clock.
   initial begin
      forever #10 clk_i = ~clk_i;
   end

   // Read data is judged against the oldest note left by the driver.
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
         `CHK("read data", exp_v, wb_dat_o)
      end
   end

   // Counts NMI pulses and cuts a hung run short.
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (nmi_req_o === 1'b1) nmi_cnt++;
      if (cyc_cnt == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick

   // One classic cycle; the request stands until ack is sampled high.
   task automatic bus(input logic [3:0] a, input logic w, input logic [3:0] s,
                      input logic [7:0] d, input logic [7:0] e);
      if (!w) exp_q.push_back({24'h0, e});
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_sel_i <= s;
      wb_dat_i <= {24'h0, d};
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   task automatic pulse(input logic [2:0] k);
      {sleep_exec_i, wake_irq_i, ext_irq_i} <= k;
      @(posedge clk_i);
      {sleep_exec_i, wake_irq_i, ext_irq_i} <= 3'h0;
   endtask : pulse

   task automatic do_reset(input logic [1:0] m);
      {mode_pin_hi_i, mode_pin_lo_i} <= m;
      rst_i <= 1'b1;
      tick(12);
      rst_i <= 1'b0;
      tick(1);
   endtask : do_reset

   // Main sequence: modes, register access, NMI, sleep, standby, watchdog.
   initial begin
      logic [1:0] m;
      logic [7:0] d;
      logic [2:0] c;
      int n;
      int nexp;
      int base;
      void'($urandom(32'hE9EEB843));
      for (int i = 0; i < 4; i++) begin
         m = 2'(i + 3);
         do_reset(m);
         bus(`ADDR_SYS_CTRL, 1'b0, 4'hF, 8'h00, `SYS_CTRL_RESET);
         bus(`ADDR_MODE_STAT, 1'b0, 4'hF, 8'h00, `MODE_STAT_FIXED | m);
         `CHK("expanded", m == 1 || m == 2, expanded_o)
         `CHK("rom", m >= 2, rom_on_o)
         `CHK("addr ports", m == 1, addr_ports_o)
         `CHK("gpio ports", m >= 2, ports_gpio_o)
         `CHK("mode 0", m == 0, mode_invalid_o)
         bus(`ADDR_SYS_CTRL, 1'b1, 4'h1, 8'h00, 8'h00);
         `CHK("ram on", m == 3, ram_on_o)
         `CHK("ram offchip", m == 1 || m == 2, ram_offchip_o)
      end
      repeat (4) begin
         d = 8'($urandom);
         bus(`ADDR_SYS_CTRL, 1'b1, 4'h1, d, 8'h00);
         d[3] = 1'b1;
         bus(`ADDR_SYS_CTRL, 1'b0, 4'hF, 8'h00, d);
         `CHK("host enable", d[1], host_if_enable_o)
         `CHK("ram on", d[0], ram_on_o)
         `CHK("ram offchip", !d[0], ram_offchip_o)
      end
      bus(`ADDR_SYS_CTRL, 1'b1, 4'hE, 8'h00, 8'h00);
      bus(`ADDR_SYS_CTRL, 1'b0, 4'hF, 8'h00, d);
      bus(`ADDR_MODE_STAT, 1'b1, 4'hF, 8'h00, 8'h00);
      bus(`ADDR_MODE_STAT, 1'b0, 4'hF, 8'h00, 8'hE6);
      bus(4'h8, 1'b0, 4'hF, 8'h00, 8'h00);
      // The mode bits follow the pins again on a later read.
      {mode_pin_hi_i, mode_pin_lo_i} <= 2'h1;
      tick(8);
      bus(`ADDR_MODE_STAT, 1'b0, 4'hF, 8'h00, 8'hE5);
      for (int s = 0; s < 2; s++) begin
         bus(`ADDR_SYS_CTRL, 1'b1, 4'h1, {5'h0, s[0], 2'h1}, 8'h00);
         nmi_pin_i <= s[0];
         tick(8);
         base = nmi_cnt;
         nmi_pin_i <= !s[0];
         tick(8);
         `CHK("nmi other edge", 0, nmi_cnt - base)
         nmi_pin_i <= s[0];
         tick(8);
         `CHK("nmi chosen edge", 1, nmi_cnt - base)
      end
      bus(`ADDR_SYS_CTRL, 1'b1, 4'h1, 8'h01, 8'h00);
      pulse(3'h4);
      tick(1);
      `CHK("sleep", 4'hA, {sleep_o, standby_o, cpu_halt_o, module_halt_o})
      pulse(3'h2);
      tick(3);
      `CHK("woken", 2'h0, {sleep_o, cpu_halt_o})
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         bus(`ADDR_SYS_CTRL, 1'b1, 4'h1, {1'b1, c, 4'h1}, 8'h00);
         pulse(3'h4);
         tick(1);
         `CHK("standby", 2'h3, {standby_o, module_halt_o})
         pulse(3'h2);
         tick(2);
         `CHK("standby held", 1'b1, standby_o)
         pulse(3'h1);
         n = 0;
         while (cpu_halt_o === 1'b1 && n < 2000) begin
            @(posedge clk_i);
            n++;
         end
         nexp = c[2] ? BASE * 16 : BASE << c;
         `CHK("settling", 1'b1, n + 1 >= nexp && n <= nexp + 4)
         bus(`ADDR_SYS_CTRL, 1'b0, 4'hF, 8'h00, {1'b1, c, 4'h9});
      end
      wdt_reset_i <= 1'b1;
      tick(3);
      wdt_reset_i <= 1'b0;
      tick(1);
      bus(`ADDR_SYS_CTRL, 1'b0, 4'hF, 8'h00, 8'h01);
      bus(`ADDR_SYS_CTRL, 1'b1, 4'h1, 8'h09, 8'h00);
      bus(`ADDR_SYS_CTRL, 1'b0, 4'hF, 8'h00, 8'h01);
      wrap_up();
   end
endmodule : system_and_mode_control_regs_test
